/* File: design/dcc_pkg.sv */
// constants, register map and state types of the dma coalescing control block
// assumes a single 40 MHz core clock and a synchronous active-low reset
package dcc_pkg;
  // timing: one enable pulse per microsecond
  localparam int unsigned DCC_CLK_PERIOD_NS = 25;
  localparam int unsigned DCC_TICK_NS = 1000;
  localparam int unsigned DCC_TICK_CYCLES = (DCC_TICK_NS + DCC_CLK_PERIOD_NS - 1) / DCC_CLK_PERIOD_NS;
  localparam logic [5:0] DCC_TICK_LAST = 6'(DCC_TICK_CYCLES - 1);
  localparam logic [5:0] DCC_TICK_ZERO = 6'h00;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] DCC_OFF_CTRL = 8'h00;
  localparam logic [7:0] DCC_OFF_RX_THR = 8'h04;
  localparam logic [7:0] DCC_OFF_TX_THR = 8'h08;
  localparam logic [7:0] DCC_OFF_WDOG = 8'h0c;
  localparam logic [7:0] DCC_OFF_MGMT_THR = 8'h10;
  localparam logic [7:0] DCC_OFF_XOFF_NORM = 8'h14;
  localparam logic [7:0] DCC_OFF_XOFF_COAL = 8'h18;
  localparam logic [7:0] DCC_OFF_PRIO_Q = 8'h1c;
  localparam logic [7:0] DCC_OFF_STATUS = 8'h20;
  // control bit positions
  localparam int DCC_CTRL_EN = 0;
  localparam int DCC_CTRL_FX = 1;
  localparam int DCC_CTRL_FD = 2;
  localparam int DCC_CTRL_TFC = 3;
  localparam int DCC_CTRL_MGI = 4;
  // status bit positions
  localparam int DCC_ST_COAL = 0;
  localparam int DCC_ST_FLUSH = 1;
  localparam int DCC_ST_LINK = 2;
  localparam int DCC_ST_ARMED = 4;
  // reset values
  localparam logic DCC_RST_BIT = 1'b0;
  localparam logic [15:0] DCC_RST_W16 = 16'h0000;
  localparam logic [3:0] DCC_RST_PRIO = 4'h0;
  localparam logic [31:0] DCC_RST_W32 = 32'h0000_0000;
  localparam logic [15:0] DCC_ONE16 = 16'h0001;
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {DCC_IDLE, DCC_FLUSH, DCC_COAL} dcc_fsm_t;
  typedef enum logic [1:0] {DCC_L0, DCC_L0S, DCC_L1} dcc_link_t;
  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } dcc_tick_t;
  typedef struct packed {
    dcc_fsm_t fsm;
    dcc_link_t link;
    logic waitreq;
    logic [31:0] rdata;
    logic en;
    logic fx;
    logic fd;
    logic tfc;
    logic mgi;
    logic [15:0] rx_thr;
    logic [15:0] tx_thr;
    logic [15:0] wdog;
    logic [15:0] mgmt_thr;
    logic [15:0] xoff_norm;
    logic [15:0] xoff_coal;
    logic [3:0] prio;
    logic armed;
    logic [15:0] wd_cnt;
    logic [15:0] lk_cnt;
    logic [15:0] xoff_out;
    logic hold;
    logic flush;
  } dcc_state_t;
endpackage

/* File: design/dcc_us_tick.sv */
// microsecond enable divider for the coalescing control block
// assumes the 40 MHz core clock; o_tick is one cycle high per microsecond
`timescale 1ns/1ps
module dcc_us_tick
  import dcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_tick
);
  dcc_tick_t st_reg;
  dcc_tick_t st_next;

  // count down and pulse on wrap
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == DCC_TICK_ZERO)
    begin
      st_next.cnt = DCC_TICK_LAST;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt - 6'h01;
    end
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '{cnt: DCC_TICK_LAST, tick: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;
endmodule

/* File: design/dcc_top.sv */
// dma coalescing control: entry/exit of coalescing, xoff watermark choice, pcie link power steps
// assumes inputs synchronous to i_clk; registers reached over avalon-mm with waitrequest
//
// Behaviour
// R1 - while coalescing, no new transaction is started on the pcie link
// R2 - while coalescing, received frames stay in the internal receive buffer
// R3 - leave coalescing when receive fill reaches the receive exit threshold
// R4 - software sizes receive threshold for latency tolerance; 70 us minimum advised
// R5 - leave coalescing based on the transmit exit threshold
// R6 - watchdog bounds how long packets, interrupts and write-backs wait
// R7 - flush-disable chooses whether a flush happens before entering coalescing
// R8 - with flush-disable set, pending interrupts and write-backs cause no exit
// R9 - coalescing xoff mark used only with flow control, coalescing, empty tx buffer
// R10 - normal xoff mark stays until the transmit buffer empties after entry
// R11 - software sets thresholds to avoid pause frames; up to one jumbo higher
// R12 - packet to a flagged priority queue forces immediate exit and dma
// R13 - coalescing is entered only while the enable bit is set
// R14 - leave coalescing based on the management buffer threshold
// R15 - idle link goes to l0s after the configured idle delay
// R16 - after a further configured delay in l0s, the link goes to l1
// R17 - entry needs enable, empty buffers, no pending dma, no exit condition
// R18 - with flush-disable clear, flush interrupts and write-backs, prefetch descriptors first
// R19 - exit when free tx space exceeds threshold and tx descriptors exist
// R20 - writing one to the self-clearing force-exit bit leaves coalescing
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [15:0] i_rx_fill,
  input wire logic i_rx_buf_empty,
  input wire logic [15:0] i_mgmt_fill,
  input wire logic i_mgmt_buf_empty,
  input wire logic [15:0] i_tx_free,
  input wire logic i_tx_buf_empty,
  input wire logic i_tx_desc_avail,
  input wire logic i_dma_pending,
  input wire logic i_rx_pkt_stored,
  input wire logic i_rx_pkt_valid,
  input wire logic [1:0] i_rx_pkt_queue,
  input wire logic i_immediate_irq,
  input wire logic i_irq_pending,
  input wire logic i_wb_pending,
  input wire logic i_tx_tail_update,
  input wire logic i_flush_done,
  input wire logic i_pcie_idle,
  input wire logic [15:0] i_idle_to_l0s_delay,
  input wire logic [15:0] i_l0s_to_l1_delay,
  output logic o_coalescing,
  output logic o_pcie_hold,
  output logic o_rx_hold,
  output logic o_flush_req,
  output logic o_xoff_enable,
  output logic [15:0] o_xoff_watermark,
  output logic [1:0] o_link_state
);
  dcc_state_t st_reg;
  dcc_state_t st_next;
  logic tick;
  logic [7:0] addr_w;
  logic wr_acc;
  logic rx_exit;
  logic tx_exit;
  logic prio_hit;
  logic mgmt_exit;
  logic wd_expire;
  logic pend_exit;
  logic exit_core;
  logic entry_ok;
  logic coal_mark;

  // byte-lane merge of a 16-bit field
  function automatic logic [15:0] be16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    be16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // microsecond enable
  dcc_us_tick u_tick (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and exit/entry terms
  assign addr_w = {i_avs_address[7:2], 2'b00};
  assign wr_acc = i_avs_write & ~st_reg.waitreq;
  assign rx_exit = i_rx_fill >= st_reg.rx_thr; // [R3]
  assign tx_exit = (i_tx_free > st_reg.tx_thr) & i_tx_desc_avail; // [R5] [R19]
  assign prio_hit = i_rx_pkt_valid & st_reg.prio[i_rx_pkt_queue]; // [R12]
  assign mgmt_exit = st_reg.mgi & (i_mgmt_fill > st_reg.mgmt_thr); // [R14]
  assign wd_expire = st_reg.armed & (st_reg.wd_cnt >= st_reg.wdog); // [R6]
  assign pend_exit = ~st_reg.fd & (i_irq_pending | i_wb_pending); // [R8]
  assign exit_core = rx_exit | tx_exit | prio_hit | i_immediate_irq | mgmt_exit | ~st_reg.en | st_reg.fx;
  // entry gate
  assign entry_ok = st_reg.en & i_rx_buf_empty & i_mgmt_buf_empty & ~i_dma_pending & ~exit_core; // [R13] [R17]
  assign coal_mark = (st_reg.fsm == DCC_COAL) & st_reg.tfc & i_tx_buf_empty; // [R9] [R10]

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    st_next = st_reg;
    // avalon slave: one wait cycle, write lands when waitrequest is seen low
    st_next.waitreq = ~((i_avs_read | i_avs_write) & st_reg.waitreq);
    if ((i_avs_read | i_avs_write) & st_reg.waitreq)
    begin
      case (addr_w)
        DCC_OFF_CTRL: st_next.rdata = {27'h0, st_reg.mgi, st_reg.tfc, st_reg.fd, st_reg.fx, st_reg.en};
        DCC_OFF_RX_THR: st_next.rdata = {16'h0, st_reg.rx_thr};
        DCC_OFF_TX_THR: st_next.rdata = {16'h0, st_reg.tx_thr};
        DCC_OFF_WDOG: st_next.rdata = {16'h0, st_reg.wdog};
        DCC_OFF_MGMT_THR: st_next.rdata = {16'h0, st_reg.mgmt_thr};
        DCC_OFF_XOFF_NORM: st_next.rdata = {16'h0, st_reg.xoff_norm};
        DCC_OFF_XOFF_COAL: st_next.rdata = {16'h0, st_reg.xoff_coal};
        DCC_OFF_PRIO_Q: st_next.rdata = {28'h0, st_reg.prio};
        DCC_OFF_STATUS: st_next.rdata = {27'h0, st_reg.armed, st_reg.link, st_reg.flush, st_reg.hold};
        default: st_next.rdata = DCC_RST_W32;
      endcase
    end
    // force-exit lives one cycle unless written
    st_next.fx = 1'b0; // [R20]
    if (wr_acc)
    begin
      case (addr_w)
        DCC_OFF_CTRL:
        begin
          if (i_avs_byteenable[0])
          begin
            st_next.en = i_avs_writedata[DCC_CTRL_EN];
            st_next.fx = i_avs_writedata[DCC_CTRL_FX]; // [R20]
            st_next.fd = i_avs_writedata[DCC_CTRL_FD];
            st_next.tfc = i_avs_writedata[DCC_CTRL_TFC];
            st_next.mgi = i_avs_writedata[DCC_CTRL_MGI];
          end
        end
        DCC_OFF_RX_THR: st_next.rx_thr = be16(st_reg.rx_thr, i_avs_writedata, i_avs_byteenable);
        DCC_OFF_TX_THR: st_next.tx_thr = be16(st_reg.tx_thr, i_avs_writedata, i_avs_byteenable);
        DCC_OFF_WDOG: st_next.wdog = be16(st_reg.wdog, i_avs_writedata, i_avs_byteenable);
        DCC_OFF_MGMT_THR: st_next.mgmt_thr = be16(st_reg.mgmt_thr, i_avs_writedata, i_avs_byteenable);
        DCC_OFF_XOFF_NORM: st_next.xoff_norm = be16(st_reg.xoff_norm, i_avs_writedata, i_avs_byteenable);
        DCC_OFF_XOFF_COAL: st_next.xoff_coal = be16(st_reg.xoff_coal, i_avs_writedata, i_avs_byteenable);
        DCC_OFF_PRIO_Q:
        begin
          if (i_avs_byteenable[0])
          begin
            st_next.prio = i_avs_writedata[3:0];
          end
        end
        default: st_next.prio = st_reg.prio;
      endcase
    end
    // coalescing state machine
    case (st_reg.fsm)
      DCC_IDLE:
      begin
        if (entry_ok)
        begin
          st_next.fsm = st_reg.fd ? DCC_COAL : DCC_FLUSH; // [R7]
        end
      end
      DCC_FLUSH:
      begin
        if (i_flush_done)
        begin
          st_next.fsm = entry_ok ? DCC_COAL : DCC_IDLE; // [R18]
        end
        else if (exit_core)
        begin
          st_next.fsm = DCC_IDLE;
        end
      end
      DCC_COAL:
      begin
        if (exit_core | wd_expire | pend_exit) // [R3] [R12] [R14] [R19] [R20]
        begin
          st_next.fsm = DCC_IDLE;
        end
      end
      default: st_next.fsm = DCC_IDLE;
    endcase
    // watchdog: armed by waiting work, counts microseconds while coalescing
    if (st_reg.fsm == DCC_COAL)
    begin
      if (i_rx_pkt_stored | i_tx_tail_update | i_irq_pending | i_wb_pending)
      begin
        st_next.armed = 1'b1; // [R6]
      end
      if (st_reg.armed & tick & (st_reg.wd_cnt < st_reg.wdog))
      begin
        st_next.wd_cnt = st_reg.wd_cnt + DCC_ONE16;
      end
    end
    else
    begin
      st_next.armed = 1'b0;
      st_next.wd_cnt = DCC_RST_W16;
    end
    // pcie link power steps
    if (!i_pcie_idle)
    begin
      st_next.link = DCC_L0;
      st_next.lk_cnt = DCC_RST_W16;
    end
    else if (tick)
    begin
      case (st_reg.link)
        DCC_L0:
        begin
          if (st_reg.lk_cnt >= i_idle_to_l0s_delay) // [R15]
          begin
            st_next.link = DCC_L0S;
            st_next.lk_cnt = DCC_RST_W16;
          end
          else
          begin
            st_next.lk_cnt = st_reg.lk_cnt + DCC_ONE16;
          end
        end
        DCC_L0S:
        begin
          if (st_reg.lk_cnt >= i_l0s_to_l1_delay) // [R16]
          begin
            st_next.link = DCC_L1;
            st_next.lk_cnt = DCC_RST_W16;
          end
          else
          begin
            st_next.lk_cnt = st_reg.lk_cnt + DCC_ONE16;
          end
        end
        DCC_L1: st_next.link = DCC_L1;
        default: st_next.link = DCC_L0;
      endcase
    end
    // outputs, registered
    st_next.hold = st_next.fsm == DCC_COAL; // [R1] [R2]
    st_next.flush = st_next.fsm == DCC_FLUSH; // [R18]
    st_next.xoff_out = coal_mark ? st_reg.xoff_coal : st_reg.xoff_norm; // [R9] [R10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '{fsm: DCC_IDLE, link: DCC_L0, waitreq: 1'b1, rdata: DCC_RST_W32,
                  en: DCC_RST_BIT, fx: DCC_RST_BIT, fd: DCC_RST_BIT, tfc: DCC_RST_BIT, mgi: DCC_RST_BIT,
                  rx_thr: DCC_RST_W16, tx_thr: DCC_RST_W16, wdog: DCC_RST_W16, mgmt_thr: DCC_RST_W16,
                  xoff_norm: DCC_RST_W16, xoff_coal: DCC_RST_W16, prio: DCC_RST_PRIO, armed: 1'b0,
                  wd_cnt: DCC_RST_W16, lk_cnt: DCC_RST_W16, xoff_out: DCC_RST_W16, hold: 1'b0, flush: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ports straight from flops
  assign o_avs_readdata = st_reg.rdata;
  assign o_avs_waitrequest = st_reg.waitreq;
  assign o_coalescing = st_reg.hold;
  assign o_pcie_hold = st_reg.hold;
  assign o_rx_hold = st_reg.hold;
  assign o_flush_req = st_reg.flush;
  assign o_xoff_enable = st_reg.tfc;
  assign o_xoff_watermark = st_reg.xoff_out;
  assign o_link_state = st_reg.link;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence enter_direct_s;
    (st_reg.fsm == DCC_IDLE) ##1 (st_reg.fsm == DCC_COAL);
  endsequence
  sequence enter_flush_s;
    (st_reg.fsm == DCC_IDLE) ##1 (st_reg.fsm == DCC_FLUSH);
  endsequence

  pcie_hold_a: assert property ((st_reg.fsm == DCC_COAL) |-> o_pcie_hold && o_rx_hold && !o_flush_req) // [R1]
    else $error("hold not asserted while coalescing");
  rx_exit_a: assert property ((st_reg.fsm == DCC_COAL) && (i_rx_fill >= st_reg.rx_thr) |=> !o_coalescing) // [R3]
    else $error("rx threshold did not end coalescing");
  tx_exit_a: assert property ((st_reg.fsm == DCC_COAL) && (i_tx_free > st_reg.tx_thr) && i_tx_desc_avail
                              |=> (st_reg.fsm == DCC_IDLE)) // [R19]
    else $error("tx space did not end coalescing");
  wdog_exit_a: assert property ((st_reg.fsm == DCC_COAL) && st_reg.armed && (st_reg.wd_cnt >= st_reg.wdog)
                                |=> (st_reg.fsm == DCC_IDLE)) // [R6]
    else $error("watchdog expiry did not end coalescing");
  flush_choice_a: assert property (enter_direct_s |-> $past(st_reg.fd) || $past(i_flush_done)) // [R7]
    else $error("entered coalescing without flush while flush enabled");
  flush_path_a: assert property (enter_flush_s |-> !$past(st_reg.fd) && o_flush_req) // [R18]
    else $error("flush started while flush disabled");
  pend_stay_a: assert property ((st_reg.fsm == DCC_COAL) && st_reg.fd && !exit_core && !wd_expire
                                |=> (st_reg.fsm == DCC_COAL)) // [R8]
    else $error("left coalescing without cause while flush disabled");
  xoff_coal_a: assert property (coal_mark |=> (o_xoff_watermark == $past(st_reg.xoff_coal))) // [R9]
    else $error("coalescing xoff mark not selected");
  xoff_norm_a: assert property (!coal_mark |=> (o_xoff_watermark == $past(st_reg.xoff_norm))) // [R10]
    else $error("normal xoff mark not kept");
  prio_exit_a: assert property ((st_reg.fsm == DCC_COAL) && prio_hit |=> !o_pcie_hold) // [R12]
    else $error("priority queue packet did not end coalescing");
  enable_gate_a: assert property ((st_reg.fsm == DCC_IDLE) && !st_reg.en |=> (st_reg.fsm == DCC_IDLE)) // [R13]
    else $error("left idle while disabled");
  mgmt_exit_a: assert property ((st_reg.fsm == DCC_COAL) && st_reg.mgi && (i_mgmt_fill > st_reg.mgmt_thr)
                                |=> (st_reg.fsm == DCC_IDLE)) // [R14]
    else $error("management threshold did not end coalescing");
  l0s_entry_a: assert property ((st_reg.link == DCC_L0) && i_pcie_idle && tick
                                && (st_reg.lk_cnt >= i_idle_to_l0s_delay) |=> (o_link_state == DCC_L0S)) // [R15]
    else $error("link did not enter l0s");
  l1_entry_a: assert property ((st_reg.link == DCC_L0S) && i_pcie_idle && tick
                               && (st_reg.lk_cnt >= i_l0s_to_l1_delay) |=> (o_link_state == DCC_L1)) // [R16]
    else $error("link did not enter l1");
  entry_cond_a: assert property (enter_direct_s |-> $past(i_rx_buf_empty && i_mgmt_buf_empty && !i_dma_pending)
                                 || $past(i_flush_done)) // [R17]
    else $error("entered coalescing with buffers busy");
  force_exit_a: assert property ((st_reg.fsm == DCC_COAL) && st_reg.fx |=> (st_reg.fsm == DCC_IDLE)
                                 && !st_reg.fx) // [R20]
    else $error("force exit ignored");
  bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered in one cycle");
endmodule

/* File: verification/dcc_host_model.sv */
// host side model: root complex that finishes flush requests and makes pcie traffic
// assumes the bench clock and a synchronous active-low reset
`timescale 1ns/1ps
module dcc_host_model
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush_req,
  input wire logic i_busy,
  input wire logic i_slow,
  output logic o_flush_done,
  output logic o_pcie_idle
);
  logic [3:0] cnt_reg;
  logic sent_reg;
  ////////////////////////////////////////////////////////////////////////////
  // link traffic only while the bench asks for it
  assign o_pcie_idle = !i_busy;
  // one done pulse per flush request, after a short or a long delay
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= 4'h0;
      sent_reg <= 1'b0;
      o_flush_done <= 1'b0;
    end
    else
    begin
      o_flush_done <= 1'b0;
      if (!i_flush_req)
      begin
        cnt_reg <= 4'h0;
        sent_reg <= 1'b0;
      end
      else if (!sent_reg)
      begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == (i_slow ? 4'hb : 4'h2))
        begin
          o_flush_done <= 1'b1;
          sent_reg <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: verification/testbench.sv */
// self-checking bench of the coalescing control block
// assumes 40 MHz clock, synchronous active-low reset, registers on avalon-mm
`timescale 1ns/1ps
module testbench
  import dcc_pkg::*;
;
  localparam logic [31:0] C_EN = 32'h1 << DCC_CTRL_EN;
  localparam logic [31:0] C_FX = 32'h1 << DCC_CTRL_FX;
  localparam logic [31:0] C_FD = 32'h1 << DCC_CTRL_FD;
  localparam logic [31:0] C_TFC = 32'h1 << DCC_CTRL_TFC;
  localparam logic [31:0] C_MGI = 32'h1 << DCC_CTRL_MGI;
  localparam logic [15:0] RX_THR = 16'h0100;
  localparam logic [15:0] TX_THR = 16'h0040;
  localparam logic [15:0] MG_THR = 16'h0020;
  localparam logic [15:0] WM_NORM = 16'h0200;
  localparam logic [15:0] WM_COAL = 16'h0280;
  logic clk, rst_n, rd, wr, wreq, rx_empty, mg_empty, tx_empty, desc, dma_pend, stored, pkt_valid;
  logic imm_irq, irq_pend, wb_pend, tail, flush_done, pcie_idle, coal, pcie_hold, rx_hold, flush_req;
  logic xoff_en, busy, slow;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] be;
  logic [15:0] rx_fill, mg_fill, tx_free, l0s_dly, l1_dly, xoff_wm;
  logic [1:0] pkt_q, link;
  int n_fail, total_checks;
  ////////////////////////////////////////////////////////////////////////////
  dcc_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_rx_fill(rx_fill), .i_rx_buf_empty(rx_empty), .i_mgmt_fill(mg_fill), .i_mgmt_buf_empty(mg_empty),
    .i_tx_free(tx_free), .i_tx_buf_empty(tx_empty), .i_tx_desc_avail(desc), .i_dma_pending(dma_pend),
    .i_rx_pkt_stored(stored), .i_rx_pkt_valid(pkt_valid), .i_rx_pkt_queue(pkt_q), .i_immediate_irq(imm_irq),
    .i_irq_pending(irq_pend), .i_wb_pending(wb_pend), .i_tx_tail_update(tail), .i_flush_done(flush_done),
    .i_pcie_idle(pcie_idle), .i_idle_to_l0s_delay(l0s_dly), .i_l0s_to_l1_delay(l1_dly), .o_coalescing(coal),
    .o_pcie_hold(pcie_hold), .o_rx_hold(rx_hold), .o_flush_req(flush_req), .o_xoff_enable(xoff_en),
    .o_xoff_watermark(xoff_wm), .o_link_state(link));
  dcc_host_model host (.i_clk(clk), .i_rst_n(rst_n), .i_flush_req(flush_req), .i_busy(busy), .i_slow(slow),
    .o_flush_done(flush_done), .o_pcie_idle(pcie_idle));
  ////////////////////////////////////////////////////////////////////////////
  // 25 ns clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bus cycle: request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat, output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= dat;
    wr <= w;
    rd <= !w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    check("waitrequest", 32'h0, {31'h0, wreq});
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] dat);
    bus(1'b1, a, dat, d);
  endtask
  function automatic logic [31:0] probe(input int k);
    case (k)
      0: probe = {31'h0, coal};
      1: probe = {31'h0, flush_req};
      default: probe = {30'h0, link};
    endcase
  endfunction
  // bounded wait for an output, then one compare
  task automatic wait_for(input int k, input logic [31:0] exp, input int lim);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (probe(k) !== exp && n < lim);
    check("wait", exp, probe(k));
  endtask
  task automatic hold_for(input int k, input logic [31:0] exp, input int n);
    repeat (n)
    begin
      @(negedge clk);
      check("hold", exp, probe(k));
    end
  endtask
  task automatic enter(input logic [31:0] ctl);
    bus_wr(DCC_OFF_CTRL, ctl);
    wait_for(0, 32'h1, 30);
  endtask
  task automatic leave();
    bus_wr(DCC_OFF_CTRL, 32'h0);
    wait_for(0, 32'h0, 6);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset values, read-back, read-only and unmapped places
  task automatic t_regs();
    bus(1'b0, DCC_OFF_CTRL, 32'h0, d);
    check("ctrl", 32'h0, d);
    bus_wr(8'h24, 32'hffff_ffff);
    bus(1'b0, 8'h24, 32'h0, d);
    check("unmapped", 32'h0, d);
    bus_wr(DCC_OFF_RX_THR, {16'hffff, RX_THR});
    bus(1'b0, DCC_OFF_RX_THR, 32'h0, d);
    check("rx_thr", {16'h0, RX_THR}, d);
    bus_wr(DCC_OFF_TX_THR, {16'h0, TX_THR});
    bus_wr(DCC_OFF_MGMT_THR, {16'h0, MG_THR});
    bus_wr(DCC_OFF_WDOG, 32'h0000_0064);
    bus_wr(DCC_OFF_XOFF_NORM, {16'h0, WM_NORM});
    bus_wr(DCC_OFF_XOFF_COAL, {16'h0, WM_COAL});
    bus_wr(DCC_OFF_PRIO_Q, 32'h0000_0004);
    bus_wr(DCC_OFF_STATUS, 32'h0000_001f);
    bus(1'b0, DCC_OFF_STATUS, 32'h0, d);
    check("status", 32'h0, d);
    hold_for(0, 32'h0, 8);
  endtask
  // entry blocked by pending dma, then holds and the rx threshold edge
  task automatic t_entry();
    @(posedge clk);
    dma_pend <= 1'b1;
    bus_wr(DCC_OFF_CTRL, C_EN | C_FD);
    hold_for(0, 32'h0, 8);
    @(posedge clk);
    dma_pend <= 1'b0;
    wait_for(0, 32'h1, 6);
    check("pcie_hold", 32'h1, {31'h0, pcie_hold});
    check("rx_hold", 32'h1, {31'h0, rx_hold});
    bus(1'b0, DCC_OFF_STATUS, 32'h0, d);
    check("status_coal", 32'h1, {31'h0, d[DCC_ST_COAL]});
    @(posedge clk);
    rx_fill <= RX_THR - 16'h1;
    hold_for(0, 32'h1, 8);
    @(posedge clk);
    rx_fill <= RX_THR;
    wait_for(0, 32'h0, 4);
    @(posedge clk);
    rx_fill <= 16'h0;
    leave();
  endtask
  // tx space, priority packet, management fill, immediate interrupt and force-exit in turn
  task automatic t_exits();
    for (int k = 0; k < 5; k++)
    begin
      enter(C_EN | C_FD | C_MGI);
      @(posedge clk);
      case (k)
        0: tx_free <= TX_THR + 16'h1;
        1: pkt_valid <= 1'b1;
        2: mg_fill <= MG_THR + 16'h1;
        3: imm_irq <= 1'b1;
        default: bus_wr(DCC_OFF_CTRL, C_EN | C_FD | C_MGI | C_FX);
      endcase
      @(posedge clk);
      pkt_valid <= 1'b0;
      imm_irq <= 1'b0;
      wait_for(0, 32'h0, 6);
      @(posedge clk);
      tx_free <= 16'h0;
      mg_fill <= 16'h0;
    end
    leave();
  endtask
  // flush before entry, pending work leaving, and the flush-disable case
  task automatic t_flush();
    @(posedge clk);
    slow <= 1'b1;
    bus_wr(DCC_OFF_CTRL, C_EN);
    wait_for(1, 32'h1, 6);
    check("coal_in_flush", 32'h0, {31'h0, coal});
    wait_for(0, 32'h1, 30);
    @(posedge clk);
    irq_pend <= 1'b1;
    wait_for(0, 32'h0, 6);
    leave();
    @(posedge clk);
    wb_pend <= 1'b1;
    enter(C_EN | C_FD);
    hold_for(0, 32'h1, 20);
    @(posedge clk);
    irq_pend <= 1'b0;
    wb_pend <= 1'b0;
    leave();
  endtask
  // watchdog of 2 us, armed by a stored packet and by a tail update
  task automatic t_wdog();
    bus_wr(DCC_OFF_WDOG, 32'h0000_0002);
    for (int k = 0; k < 2; k++)
    begin
      enter(C_EN | C_FD);
      @(posedge clk);
      stored <= (k == 0);
      tail <= (k == 1);
      @(posedge clk);
      stored <= 1'b0;
      tail <= 1'b0;
      hold_for(0, 32'h1, 30);
      wait_for(0, 32'h0, 200);
    end
    leave();
  endtask
  // watermark switch once the tx buffer empties
  task automatic t_xoff();
    @(posedge clk);
    tx_empty <= 1'b0;
    enter(C_EN | C_FD | C_TFC);
    check("xoff_en", 32'h1, {31'h0, xoff_en});
    check("wm_norm", {16'h0, WM_NORM}, {16'h0, xoff_wm});
    @(posedge clk);
    tx_empty <= 1'b1;
    repeat (3) @(negedge clk);
    check("wm_coal", {16'h0, WM_COAL}, {16'h0, xoff_wm});
    leave();
    @(negedge clk);
    check("wm_idle", {16'h0, WM_NORM}, {16'h0, xoff_wm});
  endtask
  // idle link steps to l0s after 2 to 3 us, l1 after 4 us more, back on traffic
  task automatic t_link();
    @(posedge clk);
    busy <= 1'b0;
    hold_for(2, 32'h0, 60);
    wait_for(2, 32'h1, 200);
    hold_for(2, 32'h1, 100);
    wait_for(2, 32'h2, 200);
    @(posedge clk);
    busy <= 1'b1;
    wait_for(2, 32'h0, 4);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst_n, rd, wr, dma_pend, stored, pkt_valid, imm_irq, irq_pend, wb_pend, tail, slow} = '0;
    {rx_empty, mg_empty, tx_empty, desc, busy} = '1;
    {addr, wdata, rx_fill, mg_fill, tx_free} = '0;
    be = 4'hf;
    pkt_q = 2'h2;
    l0s_dly = 16'h0002;
    l1_dly = 16'h0003;
    n_fail = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_entry();
    t_exits();
    t_flush();
    t_wdog();
    t_xoff();
    t_link();
    close_out();
  end
  // cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("[FAIL] watchdog expected done seen hang");
    close_out();
  end
endmodule
